// File: hw/sdi_pkg.sv
// Summary of operation
// R1 - One open-drain pin, half duplex only
// R2 - Bytes framed as start, eight data, stop
// R3 - Host sends commands led by command byte
// R4 - Return to looped breakpoint sets debug mode
// R5 - Most commands disabled while only looping
// R6 - Breakpoint instruction decodes from opcode 00H
// R7 - Subset outside debug mode, all inside (code: the rest only with cpu_stopped also high)
// R8 - Read protection refuses several commands
// R9 - Commands 00H, 02H, 04H, 05H always accepted
// R10 - Runtime counter command 03H debug mode only
// R11 - Protected control write cannot clear mode
// R12 - Pin released when idle, driven low only
package sdi_pkg;
	// Core clock and serial rate
	localparam int CLK_HZ = 10000000;
	localparam int DBG_BAUD = 115200;
	localparam int BIT_CYCLES = CLK_HZ / DBG_BAUD;
	localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
	localparam int BIT_CNT_W = 8;
	localparam logic [BIT_CNT_W-1:0] BIT_LAST = 8'(BIT_CYCLES - 1);
	localparam logic [BIT_CNT_W-1:0] HALF_LAST = 8'(HALF_BIT_CYCLES - 1);
	// Data bits per character
	localparam logic [3:0] DATA_BITS = 4'h8;
	// Command bytes
	localparam logic [7:0] CMD_READ_REV = 8'h00;
	localparam logic [7:0] CMD_READ_STATUS = 8'h02;
	localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
	localparam logic [7:0] CMD_WRITE_CTRL = 8'h04;
	localparam logic [7:0] CMD_READ_CTRL = 8'h05;
	// Breakpoint opcode, equal to a fully programmed flash byte
	localparam logic [7:0] BRK_OPCODE = 8'h00;
	// Revision value, arbitrary
	localparam logic [15:0] DBG_REVISION = 16'h0A01;
	// Control byte fields
	localparam int CTRL_MODE_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Status byte fields
	localparam int STAT_MODE_BIT = 7;
	localparam int STAT_PROT_BIT = 5;
	// Runtime counter width
	localparam int RUN_W = 16;
	// Command front end states
	typedef enum logic [1:0] {SDI_IDLE, SDI_GET_DATA, SDI_SEND} sdi_state_t;
endpackage

// File: hw/sdi_ser_if.sv
`timescale 1ns/1ps
// Byte stream between command core and serial pin engine
interface sdi_ser_if;
	logic rx_valid; // One-cycle pulse, received byte
	logic [7:0] rx_data; // Received byte
	logic tx_valid; // Byte offered for sending
	logic tx_ready; // Engine idle, will take byte
	logic [7:0] tx_data; // Byte to send
	modport core (input rx_valid, input rx_data, input tx_ready, output tx_valid, output tx_data);
	modport phy (output rx_valid, output rx_data, output tx_ready, input tx_valid, input tx_data);
endinterface

// File: hw/sdi_serial.sv
`timescale 1ns/1ps
// Half-duplex asynchronous byte engine on one open-drain pin
module sdi_serial (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	sdi_ser_if.phy ser
);
	// Transmit and receive share one counter set; never both at once
	typedef enum logic [1:0] {SDI_S_IDLE, SDI_S_RX, SDI_S_TX} sdi_ser_state_t;
	sdi_ser_state_t state_reg; // Engine phase
	logic [7:0] bit_cnt_reg; // Cycles within one bit
	logic [3:0] bit_idx_reg; // Bit position, 0 is start bit
	logic [9:0] shift_reg; // Character being shifted
	logic bit_end; // Last cycle of a bit period

	assign bit_end = (bit_cnt_reg == sdi_pkg::BIT_LAST);

	// Receive starts only while idle, so own transmission is never heard
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SDI_S_IDLE;
			bit_cnt_reg <= 8'h00;
			bit_idx_reg <= 4'h0;
			shift_reg <= 10'h3FF;
		end else begin
			case (state_reg)
				SDI_S_IDLE: begin
					bit_idx_reg <= 4'h0;
					if (ser.tx_valid) begin // see R1
						// Stop, data LSB first, start bit
						shift_reg <= {1'b1, ser.tx_data, 1'b0}; // see R2
						bit_cnt_reg <= 8'h00;
						state_reg <= SDI_S_TX;
					end else if (!pin_in) begin
						// Start edge: aim sampling at bit centres
						bit_cnt_reg <= sdi_pkg::BIT_LAST - sdi_pkg::HALF_LAST;
						state_reg <= SDI_S_RX;
					end
				end
				SDI_S_RX: begin
					bit_cnt_reg <= bit_end ? 8'h00 : bit_cnt_reg + 8'h01;
					if (bit_end) begin
						bit_idx_reg <= bit_idx_reg + 4'h1;
						shift_reg <= {pin_in, shift_reg[9:1]};
						// Glitch on start bit aborts the character
						if (bit_idx_reg == 4'h0 && pin_in) begin
							state_reg <= SDI_S_IDLE;
						end else if (bit_idx_reg == sdi_pkg::DATA_BITS + 4'h1) begin
							state_reg <= SDI_S_IDLE;
						end
					end
				end
				SDI_S_TX: begin
					bit_cnt_reg <= bit_end ? 8'h00 : bit_cnt_reg + 8'h01;
					if (bit_end) begin
						bit_idx_reg <= bit_idx_reg + 4'h1;
						shift_reg <= {1'b1, shift_reg[9:1]};
						if (bit_idx_reg == sdi_pkg::DATA_BITS + 4'h1) begin
							state_reg <= SDI_S_IDLE;
						end
					end
				end
				default: state_reg <= SDI_S_IDLE;
			endcase
		end
	end

	// Received byte pulse; a bad stop bit drops the byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser.rx_valid <= 1'b0;
			ser.rx_data <= 8'h00;
		end else begin
			ser.rx_valid <= 1'b0;
			if (state_reg == SDI_S_RX && bit_end
					&& bit_idx_reg == sdi_pkg::DATA_BITS + 4'h1 && pin_in) begin
				ser.rx_valid <= 1'b1; // see R2
				ser.rx_data <= shift_reg[9:2];
			end
		end
	end

	// Pin drive: low only, released for a one bit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= 1'b0; // see R12
			pin_oe <= (state_reg == SDI_S_TX) && !shift_reg[0]; // see R12
		end
	end

	// Engine ready only when fully idle
	assign ser.tx_ready = (state_reg == SDI_S_IDLE);
endmodule

// File: hw/sdi_top.sv
`timescale 1ns/1ps
// Debug command front end behind the single serial pin
module sdi_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	// Debug serial pin, open drain
	input wire logic debug_serial_pin_in,
	output logic debug_serial_pin_out,
	output logic debug_serial_pin_oe,
	// CPU side
	input wire logic cpu_fetch_valid,
	input wire logic [7:0] cpu_fetch_opcode,
	input wire logic cpu_isr_return,
	input wire logic cpu_stopped,
	// Option bit from flash
	input wire logic read_protect_option,
	// Outputs to CPU and rest of debugger
	output logic debug_mode_flag,
	output logic breakpoint_loop,
	output logic other_cmd_valid,
	output logic [7:0] other_cmd_code,
	output logic cmd_refused
);
	sdi_ser_if ser (); // Byte stream to pin engine

	sdi_pkg::sdi_state_t state_reg; // Command phase
	logic [7:0] ctrl_reg; // Debugger control byte
	logic [7:0] ctrl_next; // Control byte after a host write
	logic [sdi_pkg::RUN_W-1:0] run_cnt_reg; // Runtime counter
	logic [15:0] reply_reg; // Reply bytes, high first
	logic [1:0] reply_left_reg; // Reply bytes still to send
	logic tx_valid_reg; // Byte offered to engine
	logic [7:0] tx_data_reg; // Byte being offered
	logic brk_seen_reg; // CPU is looping on a breakpoint
	logic cmd_ok; // Command allowed right now
	logic [7:0] status_byte; // Live status view
	logic full_access; // Debug mode and stopped CPU

	// Serial pin engine, keeps the half-duplex discipline
	sdi_serial u_serial (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin_in(debug_serial_pin_in),
		.pin_out(debug_serial_pin_out),
		.pin_oe(debug_serial_pin_oe),
		.ser(ser.phy)
	);

	assign ser.tx_valid = tx_valid_reg;
	assign ser.tx_data = tx_data_reg;

	// Debug mode flag lives in the control byte
	assign debug_mode_flag = ctrl_reg[sdi_pkg::CTRL_MODE_BIT];

	// Status byte: mode and protection
	always_comb begin
		status_byte = 8'h00;
		status_byte[sdi_pkg::STAT_MODE_BIT] = ctrl_reg[sdi_pkg::CTRL_MODE_BIT];
		status_byte[sdi_pkg::STAT_PROT_BIT] = read_protect_option;
	end

	// Full command set needs a stopped CPU in debug mode
	assign full_access = debug_mode_flag && cpu_stopped; // see R5

	// Command gating table
	always_comb begin
		if (ser.rx_data == sdi_pkg::CMD_READ_REV) begin
			cmd_ok = 1'b1; // see R9
		end else if (ser.rx_data == sdi_pkg::CMD_READ_STATUS) begin
			cmd_ok = 1'b1; // see R9
		end else if (ser.rx_data == sdi_pkg::CMD_WRITE_CTRL) begin
			cmd_ok = 1'b1; // see R9
		end else if (ser.rx_data == sdi_pkg::CMD_READ_CTRL) begin
			cmd_ok = 1'b1; // see R9
		end else if (ser.rx_data == sdi_pkg::CMD_READ_RUNTIME) begin
			// Debug mode only; protection leaves it alone
			cmd_ok = debug_mode_flag; // see R10
		end else begin
			// Everything else: full access and no read protection
			cmd_ok = full_access && !read_protect_option; // see R7 see R8
		end
	end

	// Control byte as a host write would leave it
	always_comb begin
		ctrl_next = ser.rx_data;
		// Protected part: the mode flag may be set but not cleared
		if (read_protect_option && debug_mode_flag) begin
			ctrl_next[sdi_pkg::CTRL_MODE_BIT] = 1'b1; // see R11
		end
	end

	// Command sequencer; bytes arrive one at a time from the host
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= sdi_pkg::SDI_IDLE;
			reply_reg <= 16'h0000;
			reply_left_reg <= 2'h0;
		end else begin
			case (state_reg)
				sdi_pkg::SDI_IDLE: begin
					// Leading byte names the command
					if (ser.rx_valid && cmd_ok) begin // see R3
						if (ser.rx_data == sdi_pkg::CMD_READ_REV) begin
							reply_reg <= sdi_pkg::DBG_REVISION;
							reply_left_reg <= 2'h2;
							state_reg <= sdi_pkg::SDI_SEND;
						end else if (ser.rx_data == sdi_pkg::CMD_READ_STATUS) begin
							reply_reg <= {status_byte, 8'h00};
							reply_left_reg <= 2'h1;
							state_reg <= sdi_pkg::SDI_SEND;
						end else if (ser.rx_data == sdi_pkg::CMD_READ_RUNTIME) begin
							// Snapshot so both bytes are coherent
							reply_reg <= run_cnt_reg;
							reply_left_reg <= 2'h2;
							state_reg <= sdi_pkg::SDI_SEND;
						end else if (ser.rx_data == sdi_pkg::CMD_WRITE_CTRL) begin
							state_reg <= sdi_pkg::SDI_GET_DATA;
						end else if (ser.rx_data == sdi_pkg::CMD_READ_CTRL) begin
							reply_reg <= {ctrl_reg, 8'h00};
							reply_left_reg <= 2'h1;
							state_reg <= sdi_pkg::SDI_SEND;
						end
					end
				end
				sdi_pkg::SDI_GET_DATA: begin
					// Data byte of a control write
					if (ser.rx_valid) begin
						state_reg <= sdi_pkg::SDI_IDLE;
					end
				end
				sdi_pkg::SDI_SEND: begin
					// Hand over next byte once engine is free
					if (ser.tx_ready && !tx_valid_reg) begin
						reply_reg <= {reply_reg[7:0], 8'h00};
						reply_left_reg <= reply_left_reg - 2'h1;
						if (reply_left_reg == 2'h1) begin
							state_reg <= sdi_pkg::SDI_IDLE;
						end
					end
				end
				default: state_reg <= sdi_pkg::SDI_IDLE;
			endcase
		end
	end

	// Transmit offer: one cycle, engine takes it at once when idle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
		end else begin
			tx_valid_reg <= 1'b0;
			if (state_reg == sdi_pkg::SDI_SEND && ser.tx_ready && !tx_valid_reg) begin
				tx_valid_reg <= 1'b1; // see R1
				tx_data_reg <= reply_reg[15:8];
			end
		end
	end

	// Breakpoint loop tracking from the fetch stream
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			brk_seen_reg <= 1'b0;
		end else if (cpu_fetch_valid) begin
			// Opcode 00H plants a breakpoint in blank-programmed flash
			brk_seen_reg <= (cpu_fetch_opcode == sdi_pkg::BRK_OPCODE); // see R6
		end
	end

	// Control byte; breakpoint return wins over a host write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= sdi_pkg::CTRL_RESET;
		end else begin
			if (state_reg == sdi_pkg::SDI_GET_DATA && ser.rx_valid) begin
				ctrl_reg <= ctrl_next; // see R11
			end
			// Back from interrupt onto the looped breakpoint: enter debug mode
			if (cpu_isr_return && brk_seen_reg) begin
				ctrl_reg[sdi_pkg::CTRL_MODE_BIT] <= 1'b1; // see R4
			end
		end
	end

	// Runtime counter runs while the program runs, saturates at top
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_cnt_reg <= '0;
		end else if (!debug_mode_flag && run_cnt_reg != '1) begin
			run_cnt_reg <= run_cnt_reg + 16'h0001;
		end
	end

	// Status outputs to CPU and rest of debugger
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			breakpoint_loop <= 1'b0;
			other_cmd_valid <= 1'b0;
			other_cmd_code <= 8'h00;
			cmd_refused <= 1'b0;
		end else begin
			breakpoint_loop <= brk_seen_reg && !debug_mode_flag;
			other_cmd_valid <= 1'b0;
			cmd_refused <= 1'b0;
			if (state_reg == sdi_pkg::SDI_IDLE && ser.rx_valid) begin
				// Refused commands are dropped silently on the pin
				cmd_refused <= !cmd_ok; // see R5 see R8
				if (cmd_ok && ser.rx_data != sdi_pkg::CMD_READ_REV
						&& ser.rx_data != sdi_pkg::CMD_READ_STATUS
						&& ser.rx_data != sdi_pkg::CMD_READ_RUNTIME
						&& ser.rx_data != sdi_pkg::CMD_WRITE_CTRL
						&& ser.rx_data != sdi_pkg::CMD_READ_CTRL) begin
					// Full-access command handed to the rest of the debugger
					other_cmd_valid <= 1'b1; // see R7
					other_cmd_code <= ser.rx_data;
				end
			end
		end
	end
endmodule

// File: test/sdi_top_checker.sv
`timescale 1ns/1ps
// Watches the debug front end at its ports
module sdi_top_checker (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic debug_serial_pin_in,
	input wire logic debug_serial_pin_out,
	input wire logic debug_serial_pin_oe,
	input wire logic cpu_fetch_valid,
	input wire logic [7:0] cpu_fetch_opcode,
	input wire logic cpu_isr_return,
	input wire logic cpu_stopped,
	input wire logic read_protect_option,
	input wire logic debug_mode_flag,
	input wire logic breakpoint_loop,
	input wire logic other_cmd_valid,
	input wire logic [7:0] other_cmd_code,
	input wire logic cmd_refused
);
	// One clock domain, so one default for all
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// Breakpoint opcode fetched outside debug mode
	sequence s_brk;
		cpu_fetch_valid && cpu_fetch_opcode == 8'h00 && !debug_mode_flag;
	endsequence
	// Return from service routine into the loop
	// No other fetch may have replaced the looped opcode a cycle earlier
	sequence s_ret;
		!cpu_fetch_valid ##1 (breakpoint_loop && cpu_isr_return && !cpu_fetch_valid);
	endsequence
	property p_pin_low;
		debug_serial_pin_out == 1'b0;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin data not low");
	property p_oe_bit;
		$rose(debug_serial_pin_oe) |-> debug_serial_pin_oe [*8];
	endproperty
	a_oe_bit: assert property (p_oe_bit) else $error("start bit cut short");
	property p_loop;
		s_brk ##1 !debug_mode_flag |=> breakpoint_loop;
	endproperty
	a_loop: assert property (p_loop) else $error("loop not flagged");
	property p_ret;
		s_ret |=> debug_mode_flag;
	endproperty
	a_ret: assert property (p_ret) else $error("mode not entered");
	property p_other;
		other_cmd_valid |-> $past(debug_mode_flag) && $past(cpu_stopped)
			&& !$past(read_protect_option);
	endproperty
	a_other: assert property (p_other) else $error("command let through");
	property p_code;
		other_cmd_valid |-> !(other_cmd_code inside {8'h00, 8'h02, 8'h03, 8'h04, 8'h05});
	endproperty
	a_code: assert property (p_code) else $error("known code passed on");
	property p_ref;
		cmd_refused |=> !debug_serial_pin_oe [*8];
	endproperty
	a_ref: assert property (p_ref) else $error("reply after refusal");
	property p_keep;
		debug_mode_flag && read_protect_option |=> debug_mode_flag;
	endproperty
	a_keep: assert property (p_keep) else $error("mode cleared");
endmodule
bind sdi_top sdi_top_checker sdi_top_checker_i (.sys_clk, .rst_n, .debug_serial_pin_in,
	.debug_serial_pin_out, .debug_serial_pin_oe, .cpu_fetch_valid, .cpu_fetch_opcode,
	.cpu_isr_return, .cpu_stopped, .read_protect_option, .debug_mode_flag,
	.breakpoint_loop, .other_cmd_valid, .other_cmd_code, .cmd_refused);

// File: test/sdi_host_model.sv
`timescale 1ns/1ps
// Host serial port behind the pull-up, pulls low only
module sdi_host_model (
	input wire logic sys_clk,
	input wire logic pin,
	output logic host_oe
);
	localparam int B = sdi_pkg::BIT_CYCLES;
	initial host_oe = 1'b0;
	// Start, LSB first, stop; returns mid stop bit
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge sys_clk) host_oe <= ~f[i];
			repeat (i == 9 ? B / 2 : B - 1) @(posedge sys_clk);
		end
	endtask
	// Listen only, never pulls while the device talks
	task automatic recv(output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		for (int t = 0; t < 2000 && !ok; t++) begin
			@(posedge sys_clk);
			ok = !pin;
		end
		repeat (B / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (B) @(posedge sys_clk);
			d[i] = pin;
		end
		// Wait out the whole stop bit, so the engine is idle again
		repeat (B + B / 2 + 2) @(posedge sys_clk);
	endtask
endmodule

// File: test/sdi_top_tb.sv
`timescale 1ns/1ps
// Bench for the debug front end
module sdi_top_tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cpu_fetch_valid = 1'b0;
	logic [7:0] cpu_fetch_opcode = 8'hFF;
	logic cpu_isr_return = 1'b0;
	logic cpu_stopped = 1'b0;
	logic read_protect_option = 1'b0;
	logic debug_serial_pin_out, debug_serial_pin_oe, debug_mode_flag, breakpoint_loop;
	logic other_cmd_valid, cmd_refused, host_oe;
	logic [7:0] other_cmd_code;
	wire logic debug_serial_pin_in;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	// First runtime reading; the counter is frozen in debug mode
	logic [15:0] run_seen = 16'h0000;
	// Pulled-up wire, low while either side pulls
	assign debug_serial_pin_in = !(debug_serial_pin_oe || host_oe);
	sdi_top sdi_top_i (.sys_clk, .rst_n, .debug_serial_pin_in, .debug_serial_pin_out,
		.debug_serial_pin_oe, .cpu_fetch_valid, .cpu_fetch_opcode, .cpu_isr_return,
		.cpu_stopped, .read_protect_option, .debug_mode_flag, .breakpoint_loop,
		.other_cmd_valid, .other_cmd_code, .cmd_refused);
	sdi_host_model sdi_host_model_i (.sys_clk, .pin(debug_serial_pin_in), .host_oe);
	initial forever #50 sys_clk = ~sys_clk;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Expected status byte
	function automatic logic [15:0] stat(input logic m, input logic p);
		return {8'h00, m, 1'b0, p, 5'h00};
	endfunction
	// Control byte after a write; protection keeps the mode bit
	function automatic logic [15:0] ctl(input logic [7:0] d, input logic m, input logic p);
		return {8'h00, (m && p) ? (d | 8'h80) : d};
	endfunction
	// n: bytes of reply, 3 nonzero pair checked against run_seen, 0 quiet, -1 refused, -2 passed on
	task automatic cmd(input logic [7:0] c, input int n, input logic [15:0] e);
		logic [7:0] b, cd;
		logic ok, rf, ov, tx;
		logic [15:0] r;
		{rf, ov, tx, r, cd} = '0;
		sdi_host_model_i.send(c);
		if (n > 0) begin
			for (int i = 0; i < (n > 1 ? 2 : 1); i++) begin
				sdi_host_model_i.recv(b, ok);
				r = {r[7:0], b};
				check(16'(ok), 16'h0001);
			end
			if (n < 3) begin
				check(r, e);
			end else begin
				check(16'(r != 16'h0000), 16'h0001);
				if (run_seen != 16'h0000) check(r, run_seen);
				run_seen = r;
			end
		end else begin
			// Long enough to see a reply start if one came
			repeat (300) begin
				@(posedge sys_clk);
				if (cmd_refused === 1'b1) rf = 1'b1;
				if (debug_serial_pin_oe === 1'b1) tx = 1'b1;
				if (other_cmd_valid === 1'b1) {ov, cd} = {1'b1, other_cmd_code};
			end
			check(16'({tx, rf, ov}), n == -1 ? 16'h0002 : n == -2 ? 16'h0001 : 16'h0000);
			if (ov) check(16'(cd), e);
		end
	endtask
	// Cycle ceiling against a hang
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		logic [7:0] d, u;
		void'($urandom(33578));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		cmd(8'h00, 2, sdi_pkg::DBG_REVISION);
		cmd(8'h02, 1, stat(0, 0));
		cmd(8'h03, -1, 0);
		u = 8'($urandom_range(255, 6));
		cmd(u, -1, 0);
		// Plant the breakpoint fetch, then return from the routine
		cpu_fetch_valid <= 1'b1;
		cpu_fetch_opcode <= 8'h00;
		@(posedge sys_clk);
		cpu_fetch_valid <= 1'b0;
		@(posedge sys_clk);
		#1 check(16'(breakpoint_loop), 16'h0001);
		@(posedge sys_clk);
		cpu_isr_return <= 1'b1;
		@(posedge sys_clk);
		cpu_isr_return <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 check(16'(debug_mode_flag), 16'h0001);
		cmd(8'h02, 1, stat(1, 0));
		cmd(8'h03, 3, 0);
		cmd(u, -1, 0);
		cpu_stopped <= 1'b1;
		cmd(u, -2, u);
		read_protect_option <= 1'b1;
		cmd(u, -1, 0);
		cmd(8'h02, 1, stat(1, 1));
		cmd(8'h03, 3, 0);
		d = 8'($urandom()) & 8'h7F;
		cmd(8'h04, 0, 0);
		cmd(d, 0, 0);
		cmd(8'h05, 1, ctl(d, 1, 1));
		read_protect_option <= 1'b0;
		cmd(8'h04, 0, 0);
		cmd(d, 0, 0);
		cmd(8'h05, 1, ctl(d, 1, 0));
		cmd(8'h02, 1, stat(0, 0));
		tally_and_finish();
	end
endmodule
